// [hdl/fault_pkg.sv]
/*
  Shared constants of the drive fault and trip manager: fault indices,
  fault classes, setting codes, warning codes and timing counts.
  Assumes a single 200 MHz system clock.
*/
package fault_pkg;
  localparam longint CLK_HZ     = 200_000_000;
  localparam int     NUM_FAULTS = 21;
  localparam int     CODE_W     = 5;
  localparam int     SEL_W      = 8;
  localparam int     MFI_W      = 8;
  localparam int     MEAS_W     = 16;
  localparam int     PIN_FLAGS  = 20;

  // Fault classes
  typedef enum logic [1:0] {
    CLS_LEVEL = 2'b00,
    CLS_LATCH = 2'b01,
    CLS_FATAL = 2'b10
  } fault_class_t;

  // Fault indices; the reported code is index plus one
  localparam int F_OVERLOAD = 0;
  localparam int F_UNDERLOAD = 1;
  localparam int F_OVERCUR1 = 2;
  localparam int F_OVERVOLT = 3;
  localparam int F_LOWVOLT = 4;
  localparam int F_LOWVOLT2 = 5;
  localparam int F_ETHERMAL = 6;
  localparam int F_OUT_PHASE = 7;
  localparam int F_IN_PHASE = 8;
  localparam int F_DRIVE_OL = 9;
  localparam int F_NO_MOTOR = 10;
  localparam int F_OVERHEAT = 11;
  localparam int F_OVERCUR2 = 12;
  localparam int F_EXTERNAL = 13;
  localparam int F_OUT_BLOCK = 14;
  localparam int F_HW_DIAG = 15;
  localparam int F_NTC_OPEN = 16;
  localparam int F_FAN = 17;
  localparam int F_PRE_REG = 18;
  localparam int F_BRAKE = 19;
  localparam int F_SAFETY = 20;
  localparam logic [CODE_W-1:0] CODE_NONE = 5'h00;

  // Setting codes
  localparam logic [SEL_W-1:0] SEL_OFF      = 8'h00;
  localparam logic [SEL_W-1:0] NO_MOTOR_ON  = 8'h01;
  localparam logic [SEL_W-1:0] FAN_TRIP_SEL = 8'h00;
  localparam logic [SEL_W-1:0] FAN_WARN_SEL = 8'h01;
  localparam int               PHASE_OUT_BIT = 1;
  localparam int               PHASE_IN_BIT  = 2;
  localparam logic [MFI_W-1:0] MFI_EXT_TRIP = 8'h04;
  localparam logic [MFI_W-1:0] MFI_BLOCK    = 8'h05;
  localparam int               OC_RATIO     = 2;

  // Warning codes
  localparam logic [3:0] WARN_NONE     = 4'h0;
  localparam logic [3:0] WARN_FAN      = 4'h1;
  localparam logic [3:0] WARN_DRIVE_OL = 4'h2;

  // Times and derived cycle counts
  localparam longint OL150_TIME_MS   = 60000;
  localparam longint OL200_TIME_MS   = 4000;
  localparam longint PRE_REG_TIME_MS = 1000;
  localparam longint OL_WARN_PCT     = 60;
  localparam longint OL150_CYC   = OL150_TIME_MS * (CLK_HZ / 1000);
  localparam longint OL200_CYC   = OL200_TIME_MS * (CLK_HZ / 1000);
  localparam longint PRE_REG_CYC = PRE_REG_TIME_MS * (CLK_HZ / 1000);

  // Class of each fault
  function automatic fault_class_t fault_class(input int idx);
    case (idx)
      F_LOWVOLT, F_OUT_BLOCK: fault_class = CLS_LEVEL;
      F_HW_DIAG:              fault_class = CLS_FATAL;
      default:                fault_class = CLS_LATCH;
    endcase
  endfunction
endpackage

// [hdl/drive_fault_trip_manager.sv]
/*
  Fault and trip manager: qualifies protection flags with their settings,
  holds each fault by class, halts the drive, keeps the first fault and
  reports history entries and the active warning.
  Assumes pin flags are asynchronous, settings and measurements are on clk.
*/
`timescale 1ns/1ps
module drive_fault_trip_manager #(
  parameter int     NUM_INPUTS  = 7,
  parameter longint OL150_CYC   = fault_pkg::OL150_CYC,
  parameter longint OL200_CYC   = fault_pkg::OL200_CYC,
  parameter longint PRE_REG_CYC = fault_pkg::PRE_REG_CYC
) (
  input  wire logic                                   clk,
  input  wire logic                                   rstn,
  input  wire logic                                   ce,
  input  wire logic                                   running,
  input  wire logic [fault_pkg::SEL_W-1:0]            overload_trip_select,
  input  wire logic [fault_pkg::SEL_W-1:0]            underload_trip_select,
  input  wire logic [fault_pkg::SEL_W-1:0]            thermal_protect_select,
  input  wire logic [fault_pkg::SEL_W-1:0]            phase_loss_select,
  input  wire logic [fault_pkg::SEL_W-1:0]            no_motor_select,
  input  wire logic [fault_pkg::SEL_W-1:0]            fan_fault_select,
  input  wire logic                                   brake_control_output,
  input  wire logic                                   pre_regulation_active,
  input  wire logic [fault_pkg::MEAS_W-1:0]           load_level,
  input  wire logic [fault_pkg::MEAS_W-1:0]           overload_level,
  input  wire logic [fault_pkg::MEAS_W-1:0]           underload_level,
  input  wire logic [fault_pkg::MEAS_W-1:0]           output_current,
  input  wire logic [fault_pkg::MEAS_W-1:0]           rated_current,
  input  wire logic [fault_pkg::MEAS_W-1:0]           brake_release_current,
  input  wire logic [NUM_INPUTS-1:0][fault_pkg::MFI_W-1:0] mfi_function,
  input  wire logic [NUM_INPUTS-1:0]                  mfi_in,
  input  wire logic                                   dc_over_volt,
  input  wire logic                                   dc_under_volt,
  input  wire logic                                   thermal_over,
  input  wire logic                                   out_phase_open,
  input  wire logic                                   in_phase_open,
  input  wire logic                                   load_over_150,
  input  wire logic                                   load_over_200,
  input  wire logic                                   no_motor_detect,
  input  wire logic                                   heatsink_hot,
  input  wire logic                                   dc_short_current,
  input  wire logic                                   ntc_open,
  input  wire logic                                   fan_error,
  input  wire logic                                   pre_reg_feedback_low,
  input  wire logic                                   starting,
  input  wire logic                                   eeprom_error,
  input  wire logic                                   adc_offset_error,
  input  wire logic                                   watchdog_error,
  input  wire logic                                   safety_a,
  input  wire logic                                   safety_b,
  input  wire logic                                   fault_reset_in,
  output logic                                        drive_trip,
  output logic                                        output_block,
  output logic [fault_pkg::NUM_FAULTS-1:0]            fault_active,
  output logic [fault_pkg::CODE_W-1:0]                first_fault_code,
  output logic                                        history_valid,
  output logic [fault_pkg::CODE_W-1:0]                history_code,
  output logic                                        warning_active,
  output logic [3:0]                                  warning_readout
);
  localparam int NF   = fault_pkg::NUM_FAULTS;
  localparam int NP   = fault_pkg::PIN_FLAGS + NUM_INPUTS;
  localparam int OLW  = $clog2(OL150_CYC + 1);
  localparam int PRW  = $clog2(PRE_REG_CYC + 1);
  // Safety inputs rest high and the reset request low, so no false trip follows reset
  localparam logic [NP-1:0] SYNC_IDLE = NP'(3'h6);

  // Refuse settings the counters cannot serve
  if (NUM_INPUTS < 1 || OL200_CYC < 1 || OL150_CYC < OL200_CYC || PRE_REG_CYC < 1)
  begin : g_chk
    $error("drive_fault_trip_manager: bad parameter");
  end

  logic [NP-1:0] sync1_q, sync1_d, sync2_q, sync2_d;
  logic          rst_seen_q, rst_seen_d, reset_pulse;
  logic s_ov, s_uv, s_th, s_opo, s_ipo, s_o150, s_o200, s_nm, s_hs, s_dcs;
  logic s_ntc, s_fan, s_pfl, s_start, s_eep, s_adc, s_wd, s_sa, s_sb, s_rst;
  logic [NUM_INPUTS-1:0] s_mfi, ext_hit, blk_hit;
  logic [OLW-1:0]        ol150_q, ol150_d, ol200_q, ol200_d;
  logic [PRW-1:0]        pre_q, pre_d;
  logic [17:0]           oc_limit;
  logic [NF-1:0]         cond, active_q, active_d, new_set, rec;
  logic [NF-1:0]         level_mask;
  logic [fault_pkg::CODE_W-1:0] first_d, hist_code_d;
  logic                  trip_d, block_d, hist_valid_d, warn_d;
  logic [3:0]            readout_d;

  // Lowest-index set bit as a fault code
  function automatic logic [fault_pkg::CODE_W-1:0] lowest_code(input logic [NF-1:0] v);
    lowest_code = fault_pkg::CODE_NONE;
    for (int i = NF - 1; i >= 0; i--)
      if (v[i])
        lowest_code = fault_pkg::CODE_W'(i + 1);
  endfunction

  // Two-flop synchronisers for all pin flags
  always_comb
  begin
    sync1_d    = {mfi_in, dc_over_volt, dc_under_volt, thermal_over, out_phase_open,
                  in_phase_open, load_over_150, load_over_200, no_motor_detect,
                  heatsink_hot, dc_short_current, ntc_open, fan_error,
                  pre_reg_feedback_low, starting, eeprom_error, adc_offset_error,
                  watchdog_error, safety_a, safety_b, fault_reset_in};
    sync2_d    = sync1_q;
    rst_seen_d = s_rst;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      sync1_q    <= SYNC_IDLE;
      sync2_q    <= SYNC_IDLE;
      rst_seen_q <= 1'b0;
    end
    else if (ce)
    begin
      sync1_q    <= sync1_d;
      sync2_q    <= sync2_d;
      rst_seen_q <= rst_seen_d;
    end
  end

  assign {s_mfi, s_ov, s_uv, s_th, s_opo, s_ipo, s_o150, s_o200, s_nm, s_hs, s_dcs,
          s_ntc, s_fan, s_pfl, s_start, s_eep, s_adc, s_wd, s_sa, s_sb, s_rst} = sync2_q;

  // One pulse per reset request; a one-cycle request is enough
  assign reset_pulse = s_rst & ~rst_seen_q;

  // Multi-function input decode
  for (genvar g = 0; g < NUM_INPUTS; g++)
  begin : g_mfi
    assign ext_hit[g] = s_mfi[g] & (mfi_function[g] == fault_pkg::MFI_EXT_TRIP);
    assign blk_hit[g] = s_mfi[g] & (mfi_function[g] == fault_pkg::MFI_BLOCK);
  end

  // Overload accumulators and pre-regulation low-feedback timer
  always_comb
  begin
    ol150_d = ol150_q;
    ol200_d = ol200_q;
    if (s_o150)
      ol150_d = (ol150_q < OLW'(OL150_CYC)) ? ol150_q + 1'b1 : ol150_q;
    else if (ol150_q != '0)
      ol150_d = ol150_q - 1'b1;
    if (s_o200)
      ol200_d = (ol200_q < OLW'(OL200_CYC)) ? ol200_q + 1'b1 : ol200_q;
    else if (ol200_q != '0)
      ol200_d = ol200_q - 1'b1;
    pre_d = '0;
    if (pre_regulation_active && s_pfl)
      pre_d = (pre_q < PRW'(PRE_REG_CYC)) ? pre_q + 1'b1 : pre_q;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      ol150_q <= '0;
      ol200_q <= '0;
      pre_q   <= '0;
    end
    else if (ce)
    begin
      ol150_q <= ol150_d;
      ol200_q <= ol200_d;
      pre_q   <= pre_d;
    end
  end

  // Qualified protection conditions
  assign oc_limit = 18'(rated_current) * 18'(fault_pkg::OC_RATIO);
  always_comb
  begin
    cond = '0;
    cond[fault_pkg::F_OVERLOAD] = (overload_trip_select != fault_pkg::SEL_OFF)
                                  && (load_level > overload_level);
    cond[fault_pkg::F_UNDERLOAD] = (underload_trip_select != fault_pkg::SEL_OFF)
                                   && (load_level < underload_level);
    cond[fault_pkg::F_OVERCUR1] = 18'(output_current) > oc_limit;
    cond[fault_pkg::F_OVERVOLT] = s_ov;
    cond[fault_pkg::F_LOWVOLT]  = s_uv & ~running;
    cond[fault_pkg::F_LOWVOLT2] = s_uv & running;
    cond[fault_pkg::F_ETHERMAL] = (thermal_protect_select != fault_pkg::SEL_OFF) & s_th;
    cond[fault_pkg::F_OUT_PHASE] = phase_loss_select[fault_pkg::PHASE_OUT_BIT] & s_opo;
    cond[fault_pkg::F_IN_PHASE]  = phase_loss_select[fault_pkg::PHASE_IN_BIT] & s_ipo;
    cond[fault_pkg::F_DRIVE_OL] = (ol150_q >= OLW'(OL150_CYC))
                                  || (ol200_q >= OLW'(OL200_CYC));
    cond[fault_pkg::F_NO_MOTOR] = (no_motor_select == fault_pkg::NO_MOTOR_ON)
                                  && s_nm && running;
    cond[fault_pkg::F_OVERHEAT] = s_hs;
    cond[fault_pkg::F_OVERCUR2] = s_dcs;
    cond[fault_pkg::F_EXTERNAL] = |ext_hit;
    cond[fault_pkg::F_OUT_BLOCK] = |blk_hit;
    cond[fault_pkg::F_HW_DIAG] = s_eep | s_adc | s_wd;
    cond[fault_pkg::F_NTC_OPEN] = s_ntc;
    cond[fault_pkg::F_FAN] = (fan_fault_select == fault_pkg::FAN_TRIP_SEL) & s_fan;
    cond[fault_pkg::F_PRE_REG] = pre_q >= PRW'(PRE_REG_CYC);
    cond[fault_pkg::F_BRAKE] = brake_control_output && s_start
                               && (output_current < brake_release_current);
    cond[fault_pkg::F_SAFETY] = ~(s_sa & s_sb);
  end

  // Fault holding by class, first fault, history and warning
  always_comb
  begin
    for (int i = 0; i < NF; i++)
    begin
      level_mask[i] = fault_pkg::fault_class(i) == fault_pkg::CLS_LEVEL;
      case (fault_pkg::fault_class(i))
        fault_pkg::CLS_LEVEL: active_d[i] = cond[i];
        fault_pkg::CLS_LATCH: active_d[i] = cond[i] | (active_q[i] & ~reset_pulse);
        fault_pkg::CLS_FATAL: active_d[i] = cond[i] | active_q[i];
        default:              active_d[i] = cond[i];
      endcase
    end
    new_set = active_d & ~active_q;
    rec     = new_set & ~level_mask;
    trip_d  = |active_d;
    block_d = active_d[fault_pkg::F_OUT_BLOCK];
    if (active_d == '0)
      first_d = fault_pkg::CODE_NONE;
    else if (active_q == '0)
      first_d = lowest_code(new_set);
    else
      first_d = first_fault_code;
    hist_valid_d = |rec;
    hist_code_d  = lowest_code(rec);
    if (fan_fault_select == fault_pkg::FAN_WARN_SEL && s_fan)
      readout_d = fault_pkg::WARN_FAN;
    else if (64'(ol150_q) * 100 >= OL150_CYC * fault_pkg::OL_WARN_PCT)
      readout_d = fault_pkg::WARN_DRIVE_OL;
    else
      readout_d = fault_pkg::WARN_NONE;
    warn_d = readout_d != fault_pkg::WARN_NONE;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      active_q         <= '0;
      drive_trip       <= 1'b0;
      output_block     <= 1'b0;
      first_fault_code <= fault_pkg::CODE_NONE;
      history_valid    <= 1'b0;
      history_code     <= fault_pkg::CODE_NONE;
      warning_active   <= 1'b0;
      warning_readout  <= fault_pkg::WARN_NONE;
    end
    else if (ce)
    begin
      active_q         <= active_d;
      drive_trip       <= trip_d;
      output_block     <= block_d;
      first_fault_code <= first_d;
      history_valid    <= hist_valid_d;
      history_code     <= hist_code_d;
      warning_active   <= warn_d;
      warning_readout  <= readout_d;
    end
  end

  assign fault_active = active_q;

  // Checks on the held fault state
  a_fatal_hold: assert property (
    @(posedge clk) disable iff (!rstn) active_q[fault_pkg::F_HW_DIAG] |=> active_q[fault_pkg::F_HW_DIAG])
    else $error("fatal fault released without power-on reset");
  a_latch_hold: assert property (
    @(posedge clk) disable iff (!rstn) active_q[fault_pkg::F_SAFETY] && !reset_pulse
    |=> active_q[fault_pkg::F_SAFETY])
    else $error("latched fault dropped without reset");
  a_latch_clear: assert property (
    @(posedge clk) disable iff (!rstn) ce && active_q[fault_pkg::F_OVERCUR2] && reset_pulse
    && !cond[fault_pkg::F_OVERCUR2] |=> !active_q[fault_pkg::F_OVERCUR2])
    else $error("latched fault not cleared by reset");
  a_level_follow: assert property (
    @(posedge clk) disable iff (!rstn) ce && !cond[fault_pkg::F_OUT_BLOCK]
    |=> !active_q[fault_pkg::F_OUT_BLOCK] && !output_block)
    else $error("level fault outlived its condition");
  a_trip_halt: assert property (
    @(posedge clk) disable iff (!rstn) drive_trip == (|active_q))
    else $error("trip output disagrees with fault state");
  a_first_hold: assert property (
    @(posedge clk) disable iff (!rstn) (first_fault_code != fault_pkg::CODE_NONE)
    ##1 (active_q != '0) |-> $stable(first_fault_code))
    else $error("first fault code overwritten");
  a_history_level: assert property (
    @(posedge clk) disable iff (!rstn) history_valid
    |-> (history_code != fault_pkg::F_LOWVOLT + 1)
    && (history_code != fault_pkg::F_OUT_BLOCK + 1))
    else $error("level fault recorded in history");
  a_safety_trip: assert property (
    @(posedge clk) disable iff (!rstn) ce && !(s_sa && s_sb) |=> active_q[fault_pkg::F_SAFETY])
    else $error("safety input loss did not trip");
  a_drive_ol: assert property (
    @(posedge clk) disable iff (!rstn) ce && ol200_q >= OLW'(OL200_CYC)
    |=> active_q[fault_pkg::F_DRIVE_OL] && drive_trip)
    else $error("drive overload accumulator did not trip");
endmodule

// [testbench/terminal_model.sv]
/*
  Terminal strip and reset button model on the far side of the fault manager.
  Assumes bench requests change just after clk rises; open contacts pull down.
*/
`timescale 1ns/1ps
module terminal_model #(
  parameter int N    = 7,
  parameter int HOLD = 2
) (
  input  wire logic         clk,
  input  wire logic [N-1:0] close_req,
  input  wire logic         press_req,
  output logic      [N-1:0] mfi_in,
  output logic              fault_reset_in
);
  int cnt;

  // Idle contacts sit at the pull-down level
  initial
  begin
    mfi_in = '0;
    fault_reset_in = 1'b0;
    cnt = 0;
  end

  // Contacts follow the requests just after the edge
  always @(posedge clk)
    mfi_in <= #1 close_req;

  // A press holds the reset request high for HOLD cycles
  always @(posedge clk)
  begin
    if (press_req && cnt == 0)
      cnt <= HOLD - 1;
    else if (cnt > 0)
      cnt <= cnt - 1;
    fault_reset_in <= #1 press_req || cnt > 0;
  end
endmodule

// [testbench/testbench.sv]
/*
  Self-checking bench for the drive fault and trip manager.
  Assumes short accumulator counts and the terminal model on the input side.
*/
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0, rstn = 1'b0, ce = 1'b1, running, press_req, fault_reset_in;
  logic [7:0] overload_trip_select, underload_trip_select, thermal_protect_select;
  logic [7:0] phase_loss_select, no_motor_select, fan_fault_select;
  logic brake_control_output, pre_regulation_active, starting, safety_a, safety_b;
  logic [15:0] load_level, overload_level, underload_level;
  logic [15:0] output_current, rated_current, brake_release_current;
  logic [6:0][7:0] mfi_function;
  logic [6:0] mfi_in, close_req;
  logic dc_over_volt, dc_under_volt, thermal_over, out_phase_open, in_phase_open;
  logic load_over_150, load_over_200, no_motor_detect, heatsink_hot, dc_short_current;
  logic ntc_open, fan_error, pre_reg_feedback_low, eeprom_error, adc_offset_error;
  logic watchdog_error, drive_trip, output_block, history_valid, warning_active;
  logic [20:0] fault_active;
  logic [4:0] first_fault_code, history_code;
  logic [3:0] warning_readout;
  int n_errors = 0, total_checks = 0, cycles = 0;

  // Clock at 200 MHz
  always #2.5 clk = ~clk;

  drive_fault_trip_manager #(.OL150_CYC(40), .OL200_CYC(10), .PRE_REG_CYC(8)) dut (
    .clk, .rstn, .ce, .running, .overload_trip_select, .underload_trip_select,
    .thermal_protect_select, .phase_loss_select, .no_motor_select, .fan_fault_select,
    .brake_control_output, .pre_regulation_active, .load_level, .overload_level,
    .underload_level, .output_current, .rated_current, .brake_release_current,
    .mfi_function, .mfi_in, .dc_over_volt, .dc_under_volt, .thermal_over,
    .out_phase_open, .in_phase_open, .load_over_150, .load_over_200, .no_motor_detect,
    .heatsink_hot, .dc_short_current, .ntc_open, .fan_error, .pre_reg_feedback_low,
    .starting, .eeprom_error, .adc_offset_error, .watchdog_error, .safety_a, .safety_b,
    .fault_reset_in, .drive_trip, .output_block, .fault_active, .first_fault_code,
    .history_valid, .history_code, .warning_active, .warning_readout
  );

  terminal_model terminals (.clk, .close_req, .press_req, .mfi_in, .fault_reset_in);

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Cuts a hang short
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      n_errors++;
      final_report();
    end
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  // Reset button press, then time for the request to act
  task automatic clr();
    press_req = 1'b1;
    step(1);
    press_req = 1'b0;
    step(6);
  endtask

  task automatic wait_bit(input int idx);
    for (int i = 0; i < 40 && fault_active[idx] !== 1'b1; i++)
      step(1);
  endtask

  // All conditions benign, then latched faults cleared
  task automatic quiet();
    {dc_over_volt, dc_under_volt, thermal_over, out_phase_open, in_phase_open} = '0;
    {load_over_150, load_over_200, no_motor_detect, heatsink_hot, dc_short_current} = '0;
    {ntc_open, fan_error, pre_reg_feedback_low, eeprom_error, adc_offset_error} = '0;
    {watchdog_error, running, brake_control_output, pre_regulation_active, starting} = '0;
    {overload_trip_select, underload_trip_select, thermal_protect_select} = '0;
    {phase_loss_select, no_motor_select, fan_fault_select} = '0;
    {load_level, overload_level, underload_level} = {16'h0064, 16'h00c8, 16'h0032};
    {output_current, rated_current, brake_release_current} = {16'h000a, 16'h0064, 16'h0000};
    {safety_a, safety_b} = 2'b11;
    mfi_function = '0;
    close_req = '0;
    clr();
    chk("trip clear", 0, drive_trip);
    chk("first clear", 0, first_fault_code);
  endtask

  task automatic t_walk();
    ce = 1'b0;
    safety_a = 1'b0;
    step(4);
    chk("frozen", 0, fault_active[20]);
    ce = 1'b1;
    step(3);
    chk("safety a", 1, fault_active[20]);
    quiet();
    safety_b = 1'b0;
    step(3);
    chk("safety", 1, fault_active[20]);
    chk("trip", 1, drive_trip);
    chk("first", 21, first_fault_code);
    chk("hist", 1, history_valid);
    chk("hcode", 21, history_code);
    step(1);
    chk("hist pulse", 0, history_valid);
    safety_b = 1'b1;
    step(4);
    chk("held", 1, fault_active[20]);
    quiet();
    $display("walk done");
  endtask

  task automatic t_level();
    dc_under_volt = 1'b1;
    step(3);
    chk("lowvolt", 1, fault_active[4]);
    chk("no hist", 0, history_valid);
    dc_under_volt = 1'b0;
    step(3);
    chk("lowvolt gone", 0, drive_trip);
    mfi_function[2] = fault_pkg::MFI_BLOCK;
    close_req[2] = 1'b1;
    step(4);
    chk("block", 1, output_block);
    close_req[2] = 1'b0;
    step(4);
    chk("block gone", 0, output_block);
    running = 1'b1;
    dc_under_volt = 1'b1;
    step(3);
    chk("lowvolt run", 1, fault_active[5]);
    quiet();
    $display("level done");
  endtask

  task automatic t_ext();
    mfi_function[6] = fault_pkg::MFI_EXT_TRIP;
    close_req[6] = 1'b1;
    step(4);
    chk("ext", 1, fault_active[13]);
    clr();
    chk("ext refused", 1, fault_active[13]);
    close_req[6] = 1'b0;
    step(4);
    chk("ext wait", 1, fault_active[13]);
    quiet();
    $display("external done");
  endtask

  task automatic t_fatal();
    for (int k = 0; k < 3; k++)
    begin
      {eeprom_error, adc_offset_error, watchdog_error} = 3'b100 >> k;
      step(3);
      chk("diag", 1, fault_active[15]);
      {eeprom_error, adc_offset_error, watchdog_error} = '0;
      step(3);
      clr();
      chk("diag held", 1, fault_active[15]);
      rstn = 1'b0;
      step(2);
      rstn = 1'b1;
      step(2);
      chk("no false trip", 0, drive_trip);
      quiet();
      chk("diag gone", 0, fault_active[15]);
    end
    $display("fatal done");
  endtask

  task automatic t_first();
    {heatsink_hot, dc_short_current} = 2'b11;
    step(3);
    chk("first two", 12, first_fault_code);
    chk("hcode two", 12, history_code);
    chk("short", 1, fault_active[12]);
    step(1);
    chk("one entry", 0, history_valid);
    {ntc_open, dc_over_volt} = 2'b11;
    step(3);
    chk("hcode later", 4, history_code);
    chk("ntc", 1, fault_active[16]);
    chk("first kept", 12, first_fault_code);
    quiet();
    $display("first done");
  endtask

  task automatic t_gates();
    load_level = 16'h00c9;
    step(3);
    chk("ovl off", 0, fault_active[0]);
    overload_trip_select = 8'h01;
    step(3);
    chk("ovl", 1, fault_active[0]);
    quiet();
    load_level = 16'h0031;
    underload_trip_select = 8'h02;
    step(3);
    chk("unl", 1, fault_active[1]);
    quiet();
    output_current = 16'h00c8;
    step(3);
    chk("oc edge", 0, fault_active[2]);
    output_current = 16'h00c9;
    step(3);
    chk("oc", 1, fault_active[2]);
    quiet();
    {in_phase_open, out_phase_open, thermal_over} = 3'b111;
    phase_loss_select = 8'h02;
    step(3);
    chk("in off", 0, fault_active[8]);
    chk("out ph", 1, fault_active[7]);
    chk("therm off", 0, fault_active[6]);
    phase_loss_select = 8'h04;
    thermal_protect_select = 8'h03;
    step(3);
    chk("in ph", 1, fault_active[8]);
    chk("therm", 1, fault_active[6]);
    quiet();
    {no_motor_detect, running, brake_control_output, starting} = 4'hf;
    {no_motor_select, brake_release_current} = {8'h02, 16'h0014};
    step(3);
    chk("nomot off", 0, fault_active[10]);
    chk("brake", 1, fault_active[19]);
    no_motor_select = fault_pkg::NO_MOTOR_ON;
    step(3);
    chk("nomot", 1, fault_active[10]);
    quiet();
    {fan_error, fan_fault_select} = {1'b1, fault_pkg::FAN_WARN_SEL};
    step(3);
    chk("fan warn", 1, warning_active);
    chk("warn code", 1, warning_readout);
    chk("fan no trip", 0, fault_active[17]);
    fan_fault_select = fault_pkg::FAN_TRIP_SEL;
    step(3);
    chk("fan trip", 1, fault_active[17]);
    quiet();
    $display("gates done");
  endtask

  task automatic t_timed();
    {pre_regulation_active, pre_reg_feedback_low} = 2'b11;
    step(4);
    chk("prereg early", 0, fault_active[18]);
    wait_bit(18);
    chk("prereg", 1, fault_active[18]);
    quiet();
    load_over_200 = 1'b1;
    step(5);
    chk("dol early", 0, fault_active[9]);
    wait_bit(9);
    chk("dol", 1, fault_active[9]);
    load_over_200 = 1'b0;
    step(30);
    quiet();
    load_over_150 = 1'b1;
    step(26);
    chk("olw early", fault_pkg::WARN_NONE, warning_readout);
    step(1);
    chk("olw", fault_pkg::WARN_DRIVE_OL, warning_readout);
    chk("olw active", 1, warning_active);
    load_over_150 = 1'b0;
    step(30);
    chk("olw gone", fault_pkg::WARN_NONE, warning_readout);
    quiet();
    $display("timed done");
  endtask

  // Main sequence
  initial
  begin
    press_req = 1'b0;
    quiet(); // Seven of the twenty reset cycles
    step(13);
    rstn = 1'b1;
    quiet();
    t_walk();
    t_level();
    t_ext();
    t_fatal();
    t_first();
    t_gates();
    t_timed();
    final_report();
  end
endmodule
